// [pkg/eccp_pkg.sv]
// Constants, codes and types shared by the enhanced capture/compare/PWM channel
package eccp_pkg;
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_TBL = 5'h04;
    localparam logic [4:0] OFS_TBH = 5'h08;
    localparam logic [4:0] OFS_ASC = 5'h0C;
    localparam logic [4:0] OFS_PRD = 5'h10;
    localparam logic [4:0] OFS_STEER = 5'h14;
    localparam logic [4:0] OFS_FLAG = 5'h18;
    // Reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_TB = 8'h00;
    localparam logic [7:0] RST_ASC = 8'h00;
    localparam logic [7:0] RST_PRD = 8'h00;
    localparam logic [7:0] RST_STEER = 8'h01;
    // Writable bit masks
    localparam logic [7:0] MASK_TBL = 8'hDB;
    localparam logic [7:0] MASK_TBH = 8'h0F;
    localparam logic [7:0] MASK_STEER = 8'h1F;
    // Field positions
    localparam int CTL_MODE_LSB = 0;
    localparam int CTL_CFG_LSB = 6;
    localparam int ASC_STATUS_BIT = 7;
    localparam int ASC_SRC_LSB = 4;
    localparam int ASC_AC_LSB = 2;
    localparam int ASC_BD_LSB = 0;
    localparam int PRD_RSEN_BIT = 7;
    localparam int PRD_DC_LSB = 0;
    localparam int STEER_SYNC_BIT = 4;
    localparam int FLAG_BIT = 0;
    // Mode codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLR = 4'h9;
    localparam logic [3:0] MODE_CMP_FLAG = 4'hA;
    localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
    localparam logic [1:0] GRP_CAPTURE = 2'h1;
    localparam logic [1:0] GRP_COMPARE = 2'h2;
    localparam logic [1:0] GRP_PWM = 2'h3;
    // Output configurations in PWM modes
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FWD = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_REV = 2'h3;
    localparam logic [1:0] TSEL_RESERVED = 2'h3;
    // Capture prescale terminal counts
    localparam logic [3:0] CAP_LAST_4 = 4'h3;
    localparam logic [3:0] CAP_LAST_16 = 4'hF;
    // Instruction cycle is four oscillator periods of clk_sys
    localparam int OSC_PER_INSTR = 4;
    localparam logic [1:0] ICYC_LAST = 2'(OSC_PER_INSTR - 1);

    typedef enum logic [2:0] {
        SD_RUN = 3'h1,
        SD_SHUT = 3'h2,
        SD_RESUME = 3'h4
    } eccp_sd_t;
endpackage : eccp_pkg

// [pkg/eccp_link_if.sv]
// Signals between the channel core and its delay and capture helpers
`timescale 1ns/1ps
interface eccp_link_if;
    logic clear;
    logic icyc;
    logic [6:0] dly_count;
    logic pwm_in;
    logic pwm_a;
    logic pwm_b;
    logic cap_in;
    logic [1:0] cap_mode;
    logic cap_en;
    logic cap_event;
    modport ctl (output clear, icyc, dly_count, pwm_in, cap_in, cap_mode, cap_en, input pwm_a, pwm_b, cap_event);
    modport dly (input clear, icyc, dly_count, pwm_in, output pwm_a, pwm_b);
    modport cap (input clear, cap_in, cap_mode, cap_en, output cap_event);
endinterface : eccp_link_if

// [design/eccp_actdelay.sv]
// Activation delay of the complementary PWM pair
`timescale 1ns/1ps
module eccp_actdelay
(
    input wire logic clk_sys,
    input wire logic resetn,
    eccp_link_if.dly lnk
);
    import eccp_pkg::*;

    typedef struct packed {
        logic prev;
        logic pend;
        logic [6:0] cnt;
        logic a;
        logic b;
    } eccp_dly_st_t;

    eccp_dly_st_t st_reg;
    eccp_dly_st_t st_next;
    logic changed;

    assign changed = lnk.pwm_in != st_reg.prev;

    always_comb
    begin
        st_next = st_reg;
        if (lnk.clear)
        begin
            st_next = '0;
        end
        else if (changed)
        begin
            // Going-inactive side drops at once; the other waits
            st_next.prev = lnk.pwm_in;
            st_next.a = 1'b0;
            st_next.b = 1'b0;
            st_next.cnt = lnk.dly_count;
            st_next.pend = lnk.dly_count != 7'h00;
            if (lnk.dly_count == 7'h00)
            begin
                st_next.a = lnk.pwm_in;
                st_next.b = ~lnk.pwm_in;
            end
        end
        else if (st_reg.pend)
        begin
            if (lnk.icyc)
            begin
                st_next.cnt = st_reg.cnt - 7'h01;
                if (st_reg.cnt == 7'h01)
                begin
                    st_next.pend = 1'b0;
                    st_next.a = st_reg.prev;
                    st_next.b = ~st_reg.prev;
                end
            end
        end
        else
        begin
            st_next.a = st_reg.prev;
            st_next.b = ~st_reg.prev;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign lnk.pwm_a = st_reg.a;
    assign lnk.pwm_b = st_reg.b;

    a_delay_holds_off: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (!lnk.clear && changed && lnk.pwm_in && lnk.dly_count != 7'h00) |=> !st_reg.a && st_reg.pend)
        else $error("active edge passed before delay count");
endmodule : eccp_actdelay

// [design/eccp_capture.sv]
// Capture edge detection and prescaling
`timescale 1ns/1ps
module eccp_capture
(
    input wire logic clk_sys,
    input wire logic resetn,
    eccp_link_if.cap lnk
);
    import eccp_pkg::*;

    typedef struct packed {
        logic prev;
        logic [3:0] cnt;
        logic ev;
    } eccp_cap_st_t;

    eccp_cap_st_t st_reg;
    eccp_cap_st_t st_next;
    logic rise;
    logic fall;

    assign rise = lnk.cap_in & ~st_reg.prev;
    assign fall = ~lnk.cap_in & st_reg.prev;

    always_comb
    begin
        st_next = st_reg;
        st_next.prev = lnk.cap_in;
        st_next.ev = 1'b0;
        if (lnk.clear || !lnk.cap_en)
        begin
            st_next.cnt = 4'h0;
        end
        else
        begin
            case (lnk.cap_mode)
                2'h0: st_next.ev = fall;
                2'h1: st_next.ev = rise;
                2'h2:
                begin
                    if (rise)
                    begin
                        st_next.ev = st_reg.cnt == CAP_LAST_4;
                        st_next.cnt = (st_reg.cnt == CAP_LAST_4) ? 4'h0 : st_reg.cnt + 4'h1;
                    end
                end
                default:
                begin
                    if (rise)
                    begin
                        st_next.ev = st_reg.cnt == CAP_LAST_16;
                        st_next.cnt = st_reg.cnt + 4'h1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign lnk.cap_event = st_reg.ev;

    a_cap_rise_each: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (lnk.cap_en && !lnk.clear && lnk.cap_mode == 2'h1 && rise) |=> st_reg.ev)
        else $error("rising edge not captured");
    a_cap_fourth: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (lnk.cap_en && !lnk.clear && lnk.cap_mode == 2'h2 && rise && st_reg.cnt != CAP_LAST_4) |=> !st_reg.ev)
        else $error("capture before fourth edge");
endmodule : eccp_capture

// [design/eccp_top.sv]
// Enhanced capture/compare/PWM channel: registers, mode decode, shutdown, steering
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps
module eccp_top
#(
    parameter int CHANNEL = 1
)
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic pin_a_in,
    input wire logic comp1_in,
    input wire logic comp2_in,
    input wire logic fault_input_n,
    input wire logic comparator_sync,
    input wire logic timer1_tick,
    input wire logic compare_match,
    input wire logic pwm_raw,
    input wire logic pwm_period_start,
    output logic [3:0] pin_out,
    output logic [3:0] pin_oe_n,
    output logic capture_strobe,
    output logic timer_reset,
    output logic capture_compare_flag,
    output logic shutdown_status,
    output logic pwm_enable,
    output logic [2:0] cc_timer_id,
    output logic [2:0] pwm_timer_id
);
    import eccp_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] tbl;
        logic [7:0] tbh;
        logic [7:0] asc;
        logic [7:0] prd;
        logic [7:0] steer;
        logic flag;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] s_a;
        logic [1:0] s_c1;
        logic [1:0] s_c2;
        logic [1:0] s_flt;
        logic [1:0] comp_held;
        logic cmp_out;
        logic [3:0] steer_eff;
        logic [1:0] div;
        logic icyc;
        eccp_sd_t sd;
        logic [3:0] pout;
        logic [3:0] poe_n;
        logic cap_strobe;
        logic tmr_rst;
        logic clear;
        logic pwm_en;
        logic [2:0] tid_cc;
        logic [2:0] tid_pwm;
    } eccp_top_st_t;

    localparam eccp_top_st_t ST_RESET = '{
        ctrl: RST_CTRL, tbl: RST_TB, tbh: RST_TB, asc: RST_ASC, prd: RST_PRD, steer: RST_STEER,
        s_flt: 2'h3, sd: SD_RUN, poe_n: 4'hF, default: '0};

    // Two-bit field of this channel from the two binding registers
    function automatic logic [1:0] chan_tsel(input logic [7:0] lo, input logic [7:0] hi);
        case (CHANNEL)
            1: chan_tsel = lo[1:0];
            2: chan_tsel = lo[4:3];
            3: chan_tsel = lo[7:6];
            4: chan_tsel = hi[1:0];
            default: chan_tsel = hi[3:2];
        endcase
    endfunction : chan_tsel

    // Timer number 1/3/5 or 2/4/6, zero when reserved
    function automatic logic [2:0] timer_num(input logic [1:0] tsel, input logic is_pwm_timer);
        if (tsel == TSEL_RESERVED)
            timer_num = 3'h0;
        else
            timer_num = {tsel, 1'b0} + {2'h0, is_pwm_timer} + 3'h1;
    endfunction : timer_num

    // Shutdown pin action: {release, level}
    function automatic logic [1:0] sd_pin(input logic [1:0] code);
        sd_pin = {code[1], code[0] & ~code[1]};
    endfunction : sd_pin

    eccp_top_st_t st_reg;
    eccp_top_st_t st_next;
    eccp_link_if lnk ();

    logic req;
    logic wr;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic [3:0] mode;
    logic [1:0] cfg;
    logic [1:0] tsel;
    logic chan_ok;
    logic is_pwm;
    logic is_cap;
    logic is_cmp;
    logic [1:0] comp_eff;
    logic [2:0] src;
    logic cause;
    logic sw_asc_wr;
    logic [3:0] drv;
    logic [3:0] lvl;
    logic [3:0] pol;
    logic [3:0] rel;
    logic [1:0] sd_ac;
    logic [1:0] sd_bd;

    assign mode = st_reg.ctrl[CTL_MODE_LSB +: 4];
    assign cfg = st_reg.ctrl[CTL_CFG_LSB +: 2];
    assign tsel = chan_tsel(st_reg.tbl, st_reg.tbh);
    assign chan_ok = tsel != TSEL_RESERVED;
    assign is_pwm = chan_ok && mode[3:2] == GRP_PWM;
    assign is_cap = chan_ok && mode[3:2] == GRP_CAPTURE;
    assign is_cmp = chan_ok && (mode == MODE_CMP_TOGGLE || mode[3:2] == GRP_COMPARE);
    assign req = avs_read | avs_write;
    // One wait state: the request is taken at the second edge
    assign avs_waitrequest = req & ~st_reg.ack;
    assign wr = avs_write & st_reg.ack;
    assign wbyte = avs_writedata[7:0];
    assign sw_asc_wr = wr && avs_address == OFS_ASC;
    // Synchronised comparators frozen between timer 1 ticks
    assign comp_eff = comparator_sync ? st_reg.comp_held : {st_reg.s_c2[1], st_reg.s_c1[1]};
    assign src = st_reg.asc[ASC_SRC_LSB +: 3];
    assign cause = (src[2] & ~st_reg.s_flt[1]) | (src[0] & comp_eff[0]) | (src[1] & comp_eff[1]);
    assign sd_ac = sd_pin(st_reg.asc[ASC_AC_LSB +: 2]);
    assign sd_bd = sd_pin(st_reg.asc[ASC_BD_LSB +: 2]);
    assign pol = {mode[0], mode[1], mode[0], mode[1]};

    always_comb
    begin
        case (avs_address)
            OFS_CTRL: rbyte = st_reg.ctrl;
            OFS_TBL: rbyte = st_reg.tbl;
            OFS_TBH: rbyte = st_reg.tbh;
            OFS_ASC: rbyte = {st_reg.sd == SD_SHUT, st_reg.asc[6:0]};
            OFS_PRD: rbyte = st_reg.prd;
            OFS_STEER: rbyte = st_reg.steer;
            OFS_FLAG: rbyte = {7'h00, st_reg.flag};
            default: rbyte = 8'h00;
        endcase
    end

    // Pin arrangement before polarity and shutdown
    always_comb
    begin
        drv = 4'h0;
        lvl = 4'h0;
        if (is_cmp)
        begin
            drv = 4'h1;
            lvl = {3'h0, st_reg.cmp_out};
        end
        else if (is_pwm)
        begin
            case (cfg)
                CFG_SINGLE:
                begin
                    drv = st_reg.steer_eff;
                    lvl = {4{lnk.pwm_a}};
                end
                CFG_FWD:
                begin
                    drv = 4'hF;
                    lvl = {lnk.pwm_a, 2'h0, 1'b1};
                end
                CFG_HALF:
                begin
                    drv = 4'h3;
                    lvl = {2'h0, lnk.pwm_b, lnk.pwm_a};
                end
                default:
                begin
                    drv = 4'hF;
                    lvl = {1'b0, 1'b1, lnk.pwm_a, 1'b0};
                end
            endcase
            lvl = lvl ^ pol;
            if (st_reg.sd != SD_RUN)
            begin
                lvl = {sd_bd[0], sd_ac[0], sd_bd[0], sd_ac[0]};
            end
        end
        rel = (is_pwm && st_reg.sd != SD_RUN) ? {sd_bd[1], sd_ac[1], sd_bd[1], sd_ac[1]} : 4'h0;
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.s_a = {st_reg.s_a[0], pin_a_in};
        st_next.s_c1 = {st_reg.s_c1[0], comp1_in};
        st_next.s_c2 = {st_reg.s_c2[0], comp2_in};
        st_next.s_flt = {st_reg.s_flt[0], fault_input_n};
        st_next.div = st_reg.div + 2'h1;
        st_next.icyc = st_reg.div == ICYC_LAST;
        st_next.clear = 1'b0;
        st_next.tmr_rst = 1'b0;
        st_next.cap_strobe = lnk.cap_event;
        st_next.ack = req & ~st_reg.ack;
        if (req && !st_reg.ack && avs_read)
            st_next.rdata = {24'h00_0000, rbyte};
        if (!comparator_sync || timer1_tick)
            st_next.comp_held = {st_reg.s_c2[1], st_reg.s_c1[1]};
        // Flag: hardware set wins over a same-cycle clear
        if (wr && avs_address == OFS_FLAG && wbyte[FLAG_BIT])
            st_next.flag = 1'b0;
        if (wr)
        begin
            case (avs_address)
                OFS_CTRL:
                begin
                    st_next.ctrl = wbyte;
                    st_next.clear = wbyte[CTL_MODE_LSB +: 4] == MODE_OFF;
                end
                OFS_TBL: st_next.tbl = wbyte & MASK_TBL;
                OFS_TBH: st_next.tbh = wbyte & MASK_TBH;
                OFS_ASC: st_next.asc = {1'b0, wbyte[6:0]};
                OFS_PRD: st_next.prd = wbyte;
                OFS_STEER: st_next.steer = wbyte & MASK_STEER;
                default: st_next.ack = st_next.ack;
            endcase
        end
        if (is_cmp && compare_match)
        begin
            case (mode)
                MODE_CMP_TOGGLE: st_next.cmp_out = ~st_reg.cmp_out;
                MODE_CMP_SET:
                begin
                    st_next.cmp_out = 1'b1;
                    st_next.flag = 1'b1;
                end
                MODE_CMP_CLR:
                begin
                    st_next.cmp_out = 1'b0;
                    st_next.flag = 1'b1;
                end
                MODE_CMP_FLAG: st_next.flag = 1'b1;
                MODE_CMP_SPECIAL:
                begin
                    st_next.flag = 1'b1;
                    st_next.tmr_rst = 1'b1;
                end
                default: st_next.flag = st_reg.flag | st_next.flag;
            endcase
        end
        if (lnk.cap_event)
            st_next.flag = 1'b1;
        if (st_reg.clear)
            st_next.cmp_out = 1'b0;
        if (st_reg.steer[STEER_SYNC_BIT] ? pwm_period_start : st_reg.icyc)
            st_next.steer_eff = st_reg.steer[3:0];
        case (st_reg.sd)
            SD_RUN:
            begin
                if (cause || (sw_asc_wr && wbyte[ASC_STATUS_BIT]))
                    st_next.sd = SD_SHUT;
            end
            SD_SHUT:
            begin
                if (cause)
                    st_next.sd = SD_SHUT;
                else if (st_reg.prd[PRD_RSEN_BIT])
                    st_next.sd = SD_RESUME;
                else if (sw_asc_wr && !wbyte[ASC_STATUS_BIT])
                    st_next.sd = SD_RESUME;
            end
            SD_RESUME:
            begin
                if (cause)
                    st_next.sd = SD_SHUT;
                else if (pwm_period_start || !is_pwm)
                    st_next.sd = SD_RUN;
            end
            default: st_next.sd = SD_RUN;
        endcase
        st_next.poe_n = ~drv | rel;
        st_next.pout = lvl & drv & ~rel;
        st_next.pwm_en = is_pwm;
        st_next.tid_cc = timer_num(tsel, 1'b0);
        st_next.tid_pwm = timer_num(tsel, 1'b1);
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            st_reg <= ST_RESET;
        else
            st_reg <= st_next;
    end

    assign lnk.clear = st_reg.clear;
    assign lnk.icyc = st_reg.icyc;
    assign lnk.dly_count = st_reg.prd[PRD_DC_LSB +: 7];
    assign lnk.pwm_in = pwm_raw;
    assign lnk.cap_in = st_reg.s_a[1];
    assign lnk.cap_mode = mode[1:0];
    assign lnk.cap_en = is_cap;

    eccp_actdelay u_delay (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .lnk(lnk.dly)
    );

    eccp_capture u_capture (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .lnk(lnk.cap)
    );

    assign avs_readdata = st_reg.rdata;
    assign pin_out = st_reg.pout;
    assign pin_oe_n = st_reg.poe_n;
    assign capture_strobe = st_reg.cap_strobe;
    assign timer_reset = st_reg.tmr_rst;
    assign capture_compare_flag = st_reg.flag;
    assign shutdown_status = st_reg.sd == SD_SHUT;
    assign pwm_enable = st_reg.pwm_en;
    assign cc_timer_id = st_reg.tid_cc;
    assign pwm_timer_id = st_reg.tid_pwm;

    a_off_releases: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (mode == MODE_OFF) |=> (pin_oe_n == 4'hF))
        else $error("pins driven while channel off");
    a_toggle_match: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (chan_ok && mode == MODE_CMP_TOGGLE && compare_match && !st_reg.clear)
        |=> st_reg.cmp_out != $past(st_reg.cmp_out))
        else $error("compare toggle missed");
    a_set_match: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (chan_ok && mode == MODE_CMP_SET && compare_match && !st_reg.clear)
        |=> st_reg.cmp_out && st_reg.flag ##1 !pin_oe_n[0] && pin_out[0])
        else $error("set on match failed");
    a_flag_only: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (chan_ok && mode == MODE_CMP_FLAG && compare_match) |=> st_reg.flag && $stable(st_reg.cmp_out) && !timer_reset)
        else $error("flag only mode disturbed pin");
    a_special_event: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (chan_ok && mode == MODE_CMP_SPECIAL && compare_match) ##1 !compare_match
        |-> timer_reset && capture_compare_flag ##1 !timer_reset)
        else $error("special event trigger wrong");
    a_shutdown_enter: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        cause |=> shutdown_status)
        else $error("shutdown not entered");
    a_manual_hold: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (st_reg.sd == SD_SHUT && !st_reg.prd[PRD_RSEN_BIT] && !sw_asc_wr) |=> shutdown_status)
        else $error("shutdown released without software");
    a_shutdown_ac_low: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (is_pwm && cfg == CFG_FWD && st_reg.sd != SD_RUN && st_reg.asc[ASC_AC_LSB +: 2] == 2'h0)
        |=> !pin_oe_n[0] && !pin_out[0] && !pin_out[2])
        else $error("a,c not low in shutdown");
    a_steer_sync: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (st_reg.steer[STEER_SYNC_BIT] && !pwm_period_start) |=> $stable(st_reg.steer_eff))
        else $error("steering changed mid period");
    a_reserved_quiet: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        (tsel == TSEL_RESERVED) |=> pin_oe_n == 4'hF && !timer_reset && !pwm_enable)
        else $error("reserved timer select not quiet");
endmodule : eccp_top

// [dv/test_enhanced_ccp_output_control.sv]
// Self-checking bench for the enhanced capture/compare/PWM channel
`timescale 1ns/1ps
module test_enhanced_ccp_output_control;
import eccp_pkg::*;
logic clk_sys = 0, resetn = 0, avs_read = 0, avs_write = 0, pin_a_in = 0, fault_input_n = 1;
logic comp1_in = 0, comp2_in = 0, comparator_sync = 0, timer1_tick = 0, compare_match = 0;
logic pwm_raw = 0, pwm_period_start = 0, avs_waitrequest, capture_strobe, timer_reset;
logic capture_compare_flag, shutdown_status, pwm_enable;
logic [4:0] avs_address = 5'h00;
logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
logic [3:0] pin_out, pin_oe_n;
logic [2:0] cc_timer_id, pwm_timer_id;
logic [7:0] rdv;
int n_mismatch = 0, checked = 0, n_cap = 0;
eccp_top dut_u (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .pin_a_in(pin_a_in), .comp1_in(comp1_in), .comp2_in(comp2_in),
    .fault_input_n(fault_input_n), .comparator_sync(comparator_sync), .timer1_tick(timer1_tick),
    .compare_match(compare_match), .pwm_raw(pwm_raw), .pwm_period_start(pwm_period_start),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .capture_strobe(capture_strobe), .timer_reset(timer_reset),
    .capture_compare_flag(capture_compare_flag), .shutdown_status(shutdown_status),
    .pwm_enable(pwm_enable), .cc_timer_id(cc_timer_id), .pwm_timer_id(pwm_timer_id));
initial forever #20 clk_sys = ~clk_sys;
always @(posedge clk_sys) if (capture_strobe === 1'b1) n_cap <= n_cap + 1;
task chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
        n_mismatch++;
        $display("MISMATCH at %0t: seen %h expected %h", $time, s, e);
    end
endtask : chk
// Request held until the edge that samples waitrequest low
task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    rdv = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
endtask : bus
task t_regs;
    bus(0, OFS_STEER, 8'h00);
    chk(rdv, RST_STEER);
    bus(0, 5'h1C, 8'h00);
    chk(rdv, 8'h00);
    bus(1, OFS_TBL, 8'hFF);
    bus(0, OFS_TBL, 8'h00);
    chk(rdv, MASK_TBL);
endtask : t_regs
task t_timer;
    for (int i = 0; i < 4; i++)
    begin
        bus(1, OFS_TBL, 8'(i));
        repeat (3) @(negedge clk_sys);
        chk(cc_timer_id, (i == 3) ? 0 : 2 * i + 1);
        chk(pwm_timer_id, (i == 3) ? 0 : 2 * i + 2);
    end
    bus(1, OFS_TBL, 8'h00);
endtask : t_timer
task t_compare;
    logic [3:0] m [5] = '{MODE_CMP_SET, MODE_CMP_CLR, MODE_CMP_FLAG, MODE_CMP_SPECIAL, MODE_CMP_TOGGLE};
    for (int i = 0; i < 5; i++)
    begin
        bus(1, OFS_CTRL, {4'h0, m[i]});
        bus(1, OFS_FLAG, 8'h01);
        @(posedge clk_sys) compare_match <= 1'b1;
        @(posedge clk_sys) compare_match <= 1'b0;
        @(negedge clk_sys);
        chk(timer_reset, i == 3);
        chk(capture_compare_flag, i != 4);
        @(negedge clk_sys);
        chk(pin_out[0], i == 0 || i == 4);
    end
endtask : t_compare
task t_capture;
    for (int k = 0; k < 4; k++)
    begin
        bus(1, OFS_CTRL, 8'h00);
        bus(1, OFS_CTRL, 8'(4 + k));
        n_cap = 0;
        repeat (16)
        begin
            @(posedge clk_sys) pin_a_in <= 1'b1;
            repeat (4) @(posedge clk_sys);
            pin_a_in <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        repeat (8) @(negedge clk_sys);
        chk(n_cap, (k < 2) ? 16 : (k == 2) ? 4 : 1);
    end
endtask : t_capture
task t_pwm;
    bus(1, OFS_CTRL, 8'h0E);
    @(posedge clk_sys) pwm_raw <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(pin_out[0], 0);
    bus(1, OFS_CTRL, 8'h0C);
    bus(1, OFS_PRD, 8'h02);
    @(posedge clk_sys) pwm_raw <= 1'b0;
    repeat (8) @(posedge clk_sys);
    pwm_raw <= 1'b1;
    repeat (3) @(negedge clk_sys);
    chk(pin_out[0], 0);
    repeat (9) @(negedge clk_sys);
    chk({pwm_enable, pin_oe_n[0], pin_out[0]}, 3'b101);
endtask : t_pwm
// Fault shutdown first held by software, then with automatic restart and released pin
task t_shut(input logic [7:0] prd, input logic [7:0] asc);
    bus(1, OFS_CTRL, 8'h4C);
    bus(1, OFS_PRD, prd);
    bus(1, OFS_ASC, asc);
    @(posedge clk_sys) fault_input_n <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk({shutdown_status, pin_oe_n[0], pin_out[0]}, {2'b10 | asc[3], 1'b0});
    @(posedge clk_sys) fault_input_n <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(shutdown_status, !prd[7]);
    if (!prd[7]) bus(1, OFS_ASC, asc);
    @(posedge clk_sys) pwm_period_start <= 1'b1;
    @(posedge clk_sys) pwm_period_start <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({shutdown_status, pin_oe_n[0], pin_out[0]}, 3'b001);
endtask : t_shut
// Synchronised comparator shutdown waits for a timer 1 tick
task t_comp;
    bus(1, OFS_PRD, 8'h80);
    bus(1, OFS_ASC, 8'h10);
    comparator_sync <= 1'b1;
    comp1_in <= 1'b1;
    repeat (8) @(negedge clk_sys);
    chk(shutdown_status, 0);
    @(posedge clk_sys) timer1_tick <= 1'b1;
    @(posedge clk_sys) timer1_tick <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(shutdown_status, 1);
    @(posedge clk_sys) comp1_in <= 1'b0;
    comparator_sync <= 1'b0;
    repeat (8) @(negedge clk_sys);
    chk(shutdown_status, 0);
endtask : t_comp
// Synchronised steering waits for the period start
task t_steer;
    bus(1, OFS_CTRL, 8'h0C);
    bus(1, OFS_STEER, 8'h12);
    repeat (8) @(negedge clk_sys);
    chk(pin_oe_n[1:0], 2'b10);
    @(posedge clk_sys) pwm_period_start <= 1'b1;
    @(posedge clk_sys) pwm_period_start <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(pin_oe_n[1:0], 2'b01);
    bus(1, OFS_STEER, 8'h01);
endtask : t_steer
task results;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
endtask : results
initial
begin
    #400000;
    n_mismatch++;
    results();
end
initial
begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (2) @(negedge clk_sys);
    chk(pin_oe_n, 4'hF);
    t_regs();
    t_timer();
    t_compare();
    t_capture();
    t_pwm();
    t_shut(8'h00, 8'h40);
    t_shut(8'h80, 8'h48);
    t_comp();
    t_steer();
    bus(1, OFS_CTRL, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk(pin_oe_n, 4'hF);
    results();
end
endmodule : test_enhanced_ccp_output_control
